/* File: src/lssb_core.sv */
// layer setting service interpreter: node id and bit rate over can
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - reset gives node 127 and 125 kbit/s
// - only layer setting requests change id/rate
// - requests on 7e5h, answers on 7e4h
// - switch 04/01 enters configuration, no answer
// - switch 04/00 waits and resets to preoperational
// - command 11h in configuration sets node id
// - configure/store answer: cs, 00 (01 if value refused), 00
// - command 17h stores settings, then confirms
// - command 13h selector 00 picks rate index
// - index table 1M down to 10k, 5 reserved
// - command 15h activates, delay low byte first
// - wait delay, switch, wait delay again
module lssb_core
#(
   parameter int CYC_PER_MS = lssb_pkg::LSSB_CYC_PER_MS  // clocks per ms
)
(
   input  wire logic                  clk_in,
   input  wire logic                  resetn_in,
   // apb slave
   input  wire logic [11:0]           paddr_in,
   input  wire logic                  psel_in,
   input  wire logic                  penable_in,
   input  wire logic                  pwrite_in,
   input  wire logic [31:0]           pwdata_in,
   output logic [31:0]                prdata_out,
   output logic                       pready_out,
   output logic                       pslverr_out,
   // frames from and to the can controller
   input  wire logic                  rx_valid_in,
   input  wire lssb_pkg::lssb_frame_t rx_frame_in,
   output logic                       tx_valid_out,
   output lssb_pkg::lssb_frame_t      tx_frame_out,
   input  wire logic                  tx_ready_in,
   // settings towards the node
   output logic [6:0]                 node_id_out,
   output logic [3:0]                 bit_idx_out,
   output logic [9:0]                 rate_kbps_out,
   output logic                       bit_switch_out,
   output logic                       tx_hold_out,
   output logic                       nvm_store_out,
   output logic [6:0]                 nvm_node_out,
   output logic [3:0]                 nvm_idx_out,
   output logic                       preop_reset_out
);
   typedef struct packed {
      lssb_pkg::lssb_mode_t  mode;     // waiting or configuration
      lssb_pkg::lssb_sw_t    sw;       // bit-timing switch phase
      logic [6:0]            node_id;  // active node id
      logic [3:0]            act_idx;  // bit timing in use
      logic [3:0]            pend_idx; // selected, not yet active
      logic                  rsp_pend; // answer waiting for the bus
      logic                  tx_valid;
      lssb_pkg::lssb_frame_t tx_frame;
      logic                  hold;     // second switch period
      logic                  bit_sw;   // re-time pulse
      logic                  nvm_st;
      logic [6:0]            nvm_node;
      logic [3:0]            nvm_idx;
      logic                  preop;
      logic [9:0]            kbps;
      logic                  en;       // software enable of requests
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
   } lssb_core_st_t;

   lssb_core_st_t        st_ff;      // registered state
   lssb_core_st_t        nxt_st;     // next state
   lssb_pkg::lssb_cmd_t  cmd;        // decoded request
   logic                 req_ok;     // request may be taken now
   logic                 tmr_load;   // start a switch period
   logic [15:0]          tmr_ms;     // its length
   logic                 tmr_done;   // period over

   // builds a three-byte answer frame
   function automatic lssb_pkg::lssb_frame_t rsp_frame(
      input logic [7:0] cs,
      input logic [7:0] code);
      rsp_frame.id  = lssb_pkg::LSSB_RSP_ID;
      rsp_frame.dlc = lssb_pkg::LSSB_DLC_3;
      rsp_frame.b0  = cs;
      rsp_frame.b1  = code;
      rsp_frame.b2  = lssb_pkg::LSSB_RSP_OK;
   endfunction

   lssb_req_decode u_dec
   (
      .rx_valid_in (rx_valid_in),
      .rx_frame_in (rx_frame_in),
      .cmd_out     (cmd)
   );

   lssb_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr
   (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .load_in   (tmr_load),
      .ms_in     (tmr_ms),
      .done_out  (tmr_done)
   );

   // requests are dropped while an answer waits or the first period
   // runs; the can controller cannot be stalled, so nothing is queued
   assign req_ok = st_ff.en && !st_ff.rsp_pend
                   && st_ff.sw != lssb_pkg::LSSB_SW_PRE;

   // next-state logic: bus slave, switch sequence, command handling
   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.bit_sw = 1'b0;
      nxt_st.nvm_st = 1'b0;
      nxt_st.preop  = 1'b0;
      tmr_load      = 1'b0;
      tmr_ms        = 16'h0000;

      // apb: one wait state so read data leaves a flip-flop
      if (psel_in && penable_in && !st_ff.pready)
      begin
         nxt_st.pready  = 1'b1;
         nxt_st.pslverr = 1'b0;
         nxt_st.prdata  = 32'h00000000;
         case (paddr_in)
            lssb_pkg::LSSB_A_CTRL:
               nxt_st.prdata[0] = st_ff.en;
            lssb_pkg::LSSB_A_STAT:
            begin
               nxt_st.prdata[lssb_pkg::LSSB_ST_NODE +: 7] = st_ff.node_id;
               nxt_st.prdata[lssb_pkg::LSSB_ST_IDX +: 4]  = st_ff.act_idx;
               nxt_st.prdata[lssb_pkg::LSSB_ST_PEND +: 4] = st_ff.pend_idx;
               nxt_st.prdata[lssb_pkg::LSSB_ST_CONF] =
                  (st_ff.mode == lssb_pkg::LSSB_MODE_CONF);
               nxt_st.prdata[lssb_pkg::LSSB_ST_BUSY] =
                  (st_ff.sw != lssb_pkg::LSSB_SW_IDLE);
               nxt_st.prdata[lssb_pkg::LSSB_ST_HOLD] = st_ff.hold;
            end
            lssb_pkg::LSSB_A_RATE:
               nxt_st.prdata[9:0] = st_ff.kbps;
            default:
               nxt_st.pslverr = 1'b1;  // unmapped address
         endcase
      end
      else if (st_ff.pready)
      begin
         // completion edge: write takes effect here and only here;
         // id and rate are read-only so software cannot bypass lss
         nxt_st.pready  = 1'b0;
         nxt_st.pslverr = 1'b0;
         if (pwrite_in && paddr_in == lssb_pkg::LSSB_A_CTRL)
            nxt_st.en = pwdata_in[0];
      end

      // answer handed to the can controller
      if (st_ff.tx_valid && tx_ready_in)
         nxt_st.rsp_pend = 1'b0;

      // switch sequence: period, re-time, period with tx silent
      case (st_ff.sw)
         lssb_pkg::LSSB_SW_PRE:
            if (tmr_done)
            begin
               nxt_st.act_idx = st_ff.pend_idx;
               nxt_st.bit_sw  = 1'b1;
               nxt_st.sw      = lssb_pkg::LSSB_SW_POST;
               tmr_load       = 1'b1;
               tmr_ms         = {st_ff.tx_frame.b2, st_ff.tx_frame.b1};
            end
         lssb_pkg::LSSB_SW_POST:
            if (tmr_done)
               nxt_st.sw = lssb_pkg::LSSB_SW_IDLE;
         default:
            nxt_st.sw = lssb_pkg::LSSB_SW_IDLE;
      endcase

      if (req_ok)
      begin
         case (cmd)
            lssb_pkg::LSSB_CMD_CONF:
               nxt_st.mode = lssb_pkg::LSSB_MODE_CONF;
            lssb_pkg::LSSB_CMD_WAIT:
            begin
               nxt_st.mode  = lssb_pkg::LSSB_MODE_WAIT;
               nxt_st.preop = 1'b1;
            end
            lssb_pkg::LSSB_CMD_NODE:
               if (st_ff.mode == lssb_pkg::LSSB_MODE_CONF)
               begin
                  nxt_st.rsp_pend = 1'b1;
                  if (rx_frame_in.b1 >= lssb_pkg::LSSB_NODE_MIN &&
                      rx_frame_in.b1 <= lssb_pkg::LSSB_NODE_MAX)
                  begin
                     nxt_st.node_id  = rx_frame_in.b1[6:0];
                     nxt_st.tx_frame = rsp_frame(lssb_pkg::LSSB_CS_NODE,
                                          lssb_pkg::LSSB_RSP_OK);
                  end
                  else
                     nxt_st.tx_frame = rsp_frame(lssb_pkg::LSSB_CS_NODE,
                                          lssb_pkg::LSSB_RSP_ERR);
               end
            lssb_pkg::LSSB_CMD_BIT:
               if (st_ff.mode == lssb_pkg::LSSB_MODE_CONF)
               begin
                  nxt_st.rsp_pend = 1'b1;
                  // reserved index decodes to zero and is refused
                  if (rx_frame_in.b1 == lssb_pkg::LSSB_TABLE_STD &&
                      rx_frame_in.b2[7:4] == 4'h0 &&
                      lssb_pkg::lssb_rate_kbps(rx_frame_in.b2[3:0])
                         != 10'h000)
                  begin
                     nxt_st.pend_idx = rx_frame_in.b2[3:0];
                     nxt_st.tx_frame = rsp_frame(lssb_pkg::LSSB_CS_BIT,
                                          lssb_pkg::LSSB_RSP_OK);
                  end
                  else
                     nxt_st.tx_frame = rsp_frame(lssb_pkg::LSSB_CS_BIT,
                                          lssb_pkg::LSSB_RSP_ERR);
               end
            lssb_pkg::LSSB_CMD_ACT:
               if (st_ff.mode == lssb_pkg::LSSB_MODE_CONF &&
                   st_ff.sw == lssb_pkg::LSSB_SW_IDLE)
               begin
                  // delay kept in the idle answer slot for the 2nd period
                  nxt_st.tx_frame.b1 = rx_frame_in.b1;
                  nxt_st.tx_frame.b2 = rx_frame_in.b2;
                  nxt_st.sw = lssb_pkg::LSSB_SW_PRE;
                  tmr_load  = 1'b1;
                  tmr_ms    = {rx_frame_in.b2, rx_frame_in.b1};
               end
            lssb_pkg::LSSB_CMD_STORE:
               // may arrive in the second period at the new rate; the
               // answer then waits until that period is over
               if (st_ff.mode == lssb_pkg::LSSB_MODE_CONF)
               begin
                  nxt_st.nvm_st   = 1'b1;
                  nxt_st.nvm_node = st_ff.node_id;
                  nxt_st.nvm_idx  = st_ff.pend_idx;
                  nxt_st.rsp_pend = 1'b1;
                  nxt_st.tx_frame = rsp_frame(lssb_pkg::LSSB_CS_STORE,
                                       lssb_pkg::LSSB_RSP_OK);
               end
            default:
               nxt_st.rsp_pend = nxt_st.rsp_pend;
         endcase
      end

      // no frame leaves during the second period
      nxt_st.hold     = (nxt_st.sw == lssb_pkg::LSSB_SW_POST);
      nxt_st.tx_valid = nxt_st.rsp_pend && !nxt_st.hold;
      nxt_st.kbps     = lssb_pkg::lssb_rate_kbps(nxt_st.act_idx);
   end

   // state register with factory defaults
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         st_ff          <= '0;
         st_ff.node_id  <= lssb_pkg::LSSB_DEF_NODE;
         st_ff.act_idx  <= lssb_pkg::LSSB_DEF_IDX;
         st_ff.pend_idx <= lssb_pkg::LSSB_DEF_IDX;
         st_ff.kbps     <= lssb_pkg::lssb_rate_kbps(lssb_pkg::LSSB_DEF_IDX);
         st_ff.en       <= lssb_pkg::LSSB_DEF_EN;
      end
      else
         st_ff <= nxt_st;
   end

   assign prdata_out      = st_ff.prdata;
   assign pready_out      = st_ff.pready;
   assign pslverr_out     = st_ff.pslverr;
   assign tx_valid_out    = st_ff.tx_valid;
   assign tx_frame_out    = st_ff.tx_frame;
   assign node_id_out     = st_ff.node_id;
   assign bit_idx_out     = st_ff.act_idx;
   assign rate_kbps_out   = st_ff.kbps;
   assign bit_switch_out  = st_ff.bit_sw;
   assign tx_hold_out     = st_ff.hold;
   assign nvm_store_out   = st_ff.nvm_st;
   assign nvm_node_out    = st_ff.nvm_node;
   assign nvm_idx_out     = st_ff.nvm_idx;
   assign preop_reset_out = st_ff.preop;

   // checks on the interpreter
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   reset_defaults_a: assert property (
      disable iff (1'b0) !resetn_in |=> node_id_out == 7'h7f
      && bit_idx_out == 4'h4 && rate_kbps_out == 10'h07d)
      else $error("defaults wrong after reset");
   node_change_a: assert property (
      node_id_out != $past(node_id_out) |->
      $past(req_ok && cmd == lssb_pkg::LSSB_CMD_NODE))
      else $error("node id changed without request");
   idx_change_a: assert property (
      bit_idx_out != $past(bit_idx_out) |-> bit_switch_out ##1 tx_hold_out)
      else $error("rate changed outside switch");
   tx_frame_a: assert property (
      tx_valid_out |-> tx_frame_out.id == 11'h7e4
      && tx_frame_out.dlc == 4'h3 && tx_frame_out.b2 == 8'h00)
      else $error("bad answer frame");
   conf_enter_a: assert property (
      req_ok && cmd == lssb_pkg::LSSB_CMD_CONF |=>
      st_ff.mode == lssb_pkg::LSSB_MODE_CONF && !st_ff.rsp_pend)
      else $error("configuration entry wrong");
   wait_enter_a: assert property (
      req_ok && cmd == lssb_pkg::LSSB_CMD_WAIT |=>
      preop_reset_out && st_ff.mode == lssb_pkg::LSSB_MODE_WAIT ##1
      !preop_reset_out)
      else $error("waiting entry wrong");
   store_rsp_a: assert property (
      nvm_store_out |-> st_ff.rsp_pend && tx_frame_out.b0 == 8'h17
      && tx_frame_out.b1 == 8'h00)
      else $error("store without confirmation");
   ignore_wait_a: assert property (
      req_ok && st_ff.mode == lssb_pkg::LSSB_MODE_WAIT &&
      cmd inside {lssb_pkg::LSSB_CMD_NODE, lssb_pkg::LSSB_CMD_BIT,
                  lssb_pkg::LSSB_CMD_ACT, lssb_pkg::LSSB_CMD_STORE}
      |=> !st_ff.rsp_pend && !nvm_store_out
      && st_ff.sw == lssb_pkg::LSSB_SW_IDLE)
      else $error("request obeyed outside configuration");
   hold_silent_a: assert property (
      tx_hold_out |-> !tx_valid_out)
      else $error("frame sent in second period");
   act_start_a: assert property (
      req_ok && cmd == lssb_pkg::LSSB_CMD_ACT &&
      st_ff.mode == lssb_pkg::LSSB_MODE_CONF &&
      st_ff.sw == lssb_pkg::LSSB_SW_IDLE |=>
      st_ff.sw == lssb_pkg::LSSB_SW_PRE && !bit_switch_out)
      else $error("activation not started");

   node_rsp_c: cover property (tx_valid_out && tx_ready_in &&
      tx_frame_out.b0 == 8'h11);
   rate_switch_c: cover property (bit_switch_out);
   store_hold_c: cover property (tx_hold_out && nvm_store_out);
   preop_c: cover property (preop_reset_out);
endmodule // lssb_core
`default_nettype wire

/* File: src/lssb_pkg.sv */
// shared constants, types and decode helpers for the lss node/bit-rate block
`default_nettype none
package lssb_pkg;
   // can identifiers of the layer setting channel
   localparam logic [10:0] LSSB_REQ_ID    = 11'h7e5;  // master -> node
   localparam logic [10:0] LSSB_RSP_ID    = 11'h7e4;  // node -> master
   // command specifiers and byte values
   localparam logic [7:0]  LSSB_CS_SWITCH = 8'h04;    // switch state global
   localparam logic [7:0]  LSSB_CS_NODE   = 8'h11;    // configure node id
   localparam logic [7:0]  LSSB_CS_BIT    = 8'h13;    // configure bit timing
   localparam logic [7:0]  LSSB_CS_ACT    = 8'h15;    // activate bit timing
   localparam logic [7:0]  LSSB_CS_STORE  = 8'h17;    // store configuration
   localparam logic [7:0]  LSSB_SW_TO_CONF = 8'h01;   // enter configuration
   localparam logic [7:0]  LSSB_SW_TO_WAIT = 8'h00;   // enter waiting
   localparam logic [7:0]  LSSB_TABLE_STD = 8'h00;    // bit-rate table selector
   localparam logic [7:0]  LSSB_RSP_OK    = 8'h00;    // success code
   localparam logic [7:0]  LSSB_RSP_ERR   = 8'h01;    // refused value code
   localparam logic [7:0]  LSSB_NODE_MIN  = 8'h01;    // lowest legal node id
   localparam logic [7:0]  LSSB_NODE_MAX  = 8'h7f;    // highest legal node id
   localparam logic [3:0]  LSSB_DLC_1     = 4'h1;
   localparam logic [3:0]  LSSB_DLC_2     = 4'h2;
   localparam logic [3:0]  LSSB_DLC_3     = 4'h3;
   // values after reset
   localparam logic [6:0]  LSSB_DEF_NODE  = 7'h7f;    // node id 127
   localparam logic [3:0]  LSSB_DEF_IDX   = 4'h4;     // 125 kbit/s
   localparam logic        LSSB_DEF_EN    = 1'b1;     // requests accepted
   // timing: switch delay unit and clock
   localparam int          LSSB_CLK_NS    = 100;      // 10 mhz clock
   localparam int          LSSB_MS_NS     = 1000000;  // 1 ms delay unit
   localparam int          LSSB_CYC_PER_MS = LSSB_MS_NS / LSSB_CLK_NS;
   // apb register offsets
   localparam logic [11:0] LSSB_A_CTRL    = 12'h000;
   localparam logic [11:0] LSSB_A_STAT    = 12'h004;
   localparam logic [11:0] LSSB_A_RATE    = 12'h008;
   // status word field positions
   localparam int          LSSB_ST_NODE   = 0;        // 7 bits
   localparam int          LSSB_ST_IDX    = 8;        // 4 bits, active
   localparam int          LSSB_ST_PEND   = 12;       // 4 bits, selected
   localparam int          LSSB_ST_CONF   = 16;
   localparam int          LSSB_ST_BUSY   = 17;
   localparam int          LSSB_ST_HOLD   = 18;

   // one can frame, up to three data bytes
   typedef struct packed {
      logic [10:0] id;
      logic [3:0]  dlc;
      logic [7:0]  b0;
      logic [7:0]  b1;
      logic [7:0]  b2;
   } lssb_frame_t;

   typedef enum logic [2:0] {
      LSSB_CMD_NONE  = 3'h0,
      LSSB_CMD_CONF  = 3'h1,
      LSSB_CMD_WAIT  = 3'h2,
      LSSB_CMD_NODE  = 3'h3,
      LSSB_CMD_BIT   = 3'h4,
      LSSB_CMD_ACT   = 3'h5,
      LSSB_CMD_STORE = 3'h6
   } lssb_cmd_t;

   typedef enum logic {
      LSSB_MODE_WAIT = 1'b0,
      LSSB_MODE_CONF = 1'b1
   } lssb_mode_t;

   typedef enum logic [1:0] {
      LSSB_SW_IDLE = 2'h0,   // no switch in progress
      LSSB_SW_PRE  = 2'h1,   // first period, old timing
      LSSB_SW_POST = 2'h2    // second period, new timing, tx silent
   } lssb_sw_t;

   // bit-rate index to kbit/s, zero for reserved or unknown
   function automatic logic [9:0] lssb_rate_kbps(input logic [3:0] idx);
      case (idx)
         4'h0:    lssb_rate_kbps = 10'h3e8;
         4'h1:    lssb_rate_kbps = 10'h320;
         4'h2:    lssb_rate_kbps = 10'h1f4;
         4'h3:    lssb_rate_kbps = 10'h0fa;
         4'h4:    lssb_rate_kbps = 10'h07d;
         4'h6:    lssb_rate_kbps = 10'h032;
         4'h7:    lssb_rate_kbps = 10'h014;
         4'h8:    lssb_rate_kbps = 10'h00a;
         default: lssb_rate_kbps = 10'h000;
      endcase
   endfunction
endpackage
`default_nettype wire

/* File: src/lssb_req_decode.sv */
// classifies a received frame into a layer setting command
`timescale 1ns/1ps
`default_nettype none
module lssb_req_decode
(
   input  wire logic                 rx_valid_in,  // frame strobe
   input  wire lssb_pkg::lssb_frame_t rx_frame_in, // received frame
   output var  lssb_pkg::lssb_cmd_t  cmd_out       // decoded command
);
   // pure decode; length must match exactly, other ids are not ours
   always_comb
   begin
      cmd_out = lssb_pkg::LSSB_CMD_NONE;
      if (rx_valid_in && rx_frame_in.id == lssb_pkg::LSSB_REQ_ID)
      begin
         case (rx_frame_in.b0)
            lssb_pkg::LSSB_CS_SWITCH:
               if (rx_frame_in.dlc == lssb_pkg::LSSB_DLC_2)
               begin
                  if (rx_frame_in.b1 == lssb_pkg::LSSB_SW_TO_CONF)
                     cmd_out = lssb_pkg::LSSB_CMD_CONF;
                  else if (rx_frame_in.b1 == lssb_pkg::LSSB_SW_TO_WAIT)
                     cmd_out = lssb_pkg::LSSB_CMD_WAIT;
               end
            lssb_pkg::LSSB_CS_NODE:
               if (rx_frame_in.dlc == lssb_pkg::LSSB_DLC_2)
                  cmd_out = lssb_pkg::LSSB_CMD_NODE;
            lssb_pkg::LSSB_CS_BIT:
               if (rx_frame_in.dlc == lssb_pkg::LSSB_DLC_3)
                  cmd_out = lssb_pkg::LSSB_CMD_BIT;
            lssb_pkg::LSSB_CS_ACT:
               if (rx_frame_in.dlc == lssb_pkg::LSSB_DLC_3)
                  cmd_out = lssb_pkg::LSSB_CMD_ACT;
            lssb_pkg::LSSB_CS_STORE:
               if (rx_frame_in.dlc == lssb_pkg::LSSB_DLC_1)
                  cmd_out = lssb_pkg::LSSB_CMD_STORE;
            default:
               cmd_out = lssb_pkg::LSSB_CMD_NONE;
         endcase
      end
   end
endmodule // lssb_req_decode
`default_nettype wire

/* File: src/lssb_ms_timer.sv */
// millisecond down-timer for the bit-timing switch periods
`timescale 1ns/1ps
`default_nettype none
module lssb_ms_timer
#(
   parameter int CYC_PER_MS = lssb_pkg::LSSB_CYC_PER_MS  // clocks per ms
)
(
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic        load_in,   // start a period
   input  wire logic [15:0] ms_in,     // period length in ms
   output logic             done_out   // one-cycle pulse at period end
);
   localparam logic [23:0] PRE_LAST = 24'(CYC_PER_MS - 1);

   typedef struct packed {
      logic        run;      // period in progress
      logic [15:0] ms_left;  // whole ms still to wait
      logic [23:0] pre;      // cycles within current ms
      logic        done;
   } lssb_tmr_st_t;

   lssb_tmr_st_t st_ff;
   lssb_tmr_st_t nxt_st;

   // a zero length period ends two cycles after load
   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      if (load_in)
      begin
         nxt_st.run     = 1'b1;
         nxt_st.ms_left = ms_in;
         nxt_st.pre     = 24'h000000;
      end
      else if (st_ff.run)
      begin
         if (st_ff.ms_left == 16'h0000)
         begin
            nxt_st.run  = 1'b0;
            nxt_st.done = 1'b1;
         end
         else if (st_ff.pre == PRE_LAST)
         begin
            nxt_st.pre     = 24'h000000;
            nxt_st.ms_left = st_ff.ms_left - 16'h0001;
         end
         else
            nxt_st.pre = st_ff.pre + 24'h000001;
      end
   end

   // state register
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign done_out = st_ff.done;
endmodule // lssb_ms_timer
`default_nettype wire

/* File: verification/lssb_master_model.sv */
// can master model: sends requests, takes answers
`timescale 1ns/1ps
`default_nettype none
module lssb_master_model
(
   input  wire logic             clk_in,
   input  wire logic             slow_in,     // stall answers
   output logic                  rx_valid_out,
   output lssb_pkg::lssb_frame_t rx_frame_out,
   output logic                  tx_ready_out
);
   initial
   begin
      rx_valid_out = 1'b0;
      rx_frame_out = '0;
      tx_ready_out = 1'b0;
   end
   // stalls at random so answers must stand
   always @(posedge clk_in) tx_ready_out <= !slow_in;
   // one request strobe, then the line is scrambled
   task automatic send(input logic [3:0] l, input logic [23:0] d);
      @(posedge clk_in);
      rx_frame_out <= {lssb_pkg::LSSB_REQ_ID, l, d};
      rx_valid_out <= 1'b1;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_frame_out <= ~rx_frame_out;
   endtask
endmodule // lssb_master_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the lss interpreter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_in = 0, resetn_in = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic pready, pslverr, e, rxv, rdy, txv, sw, hold, prer, nst;
   logic [15:0] rnd = 16'h3a14; // lfsr seed 14868
   lssb_pkg::lssb_frame_t rxf, txf;
   logic [6:0] node, nvn, nd;
   logic [3:0] idx, nvi;
   logic [9:0] kb;
   logic [38:0] exp_q[$]; // answers still owed
   int bad_count = 0, n_tests = 0, cyc = 0, n;
   localparam logic [9:0] KBPS [9] = '{10'h3e8, 10'h320, 10'h1f4,
      10'h0fa, 10'h07d, 10'h000, 10'h032, 10'h014, 10'h00a};
   lssb_core #(.CYC_PER_MS(10)) dut (.clk_in(clk_in),
      .resetn_in(resetn_in), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .rx_valid_in(rxv), .rx_frame_in(rxf), .tx_valid_out(txv),
      .tx_frame_out(txf), .tx_ready_in(rdy), .node_id_out(node),
      .bit_idx_out(idx), .rate_kbps_out(kb), .bit_switch_out(sw),
      .tx_hold_out(hold), .nvm_store_out(nst), .nvm_node_out(nvn),
      .nvm_idx_out(nvi), .preop_reset_out(prer));
   lssb_master_model m (.clk_in(clk_in), .slow_in(rnd[0]),
      .rx_valid_out(rxv), .rx_frame_out(rxf), .tx_ready_out(rdy));
   initial forever #50 clk_in = ~clk_in;
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input string s, input logic [38:0] x, y);
      n_tests++;
      if (x !== y)
      begin
         bad_count++;
         $display("CHECK FAILED %s exp %h got %h", s, x, y);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // apb master: hold until pready seen high
   // no wait limit of its own: only the bench timeout ends a hang
   task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] wd);
      @(posedge clk_in);
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      psel <= 1'b1;
      @(posedge clk_in);
      penable <= 1'b1;
      while (pready !== 1'b1) @(posedge clk_in);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one request; wait out its answer before the next
   task automatic req(input logic [3:0] l, input logic [23:0] d,
      input logic a, input logic f);
      if (a) exp_q.push_back({11'h7e4, 4'h3, d[23:16], 7'h0, f, 8'h0});
      m.send(l, d);
      for (n = 0; exp_q.size() > 0 && n < 50; n++) @(posedge clk_in);
      chk("answer", 0, exp_q.size());
      repeat (3) @(posedge clk_in);
   endtask
   // answer monitor: oldest note against each accepted frame
   always @(posedge clk_in)
   begin
      if (txv === 1'b1 && rdy === 1'b1)
         chk("tx", exp_q.size() ? exp_q.pop_front() : 'x, txf);
      // the store pulse must come with its confirmation loaded
      if (nst === 1'b1)
         chk("nvm_st", 8'h17, txf.b0);
   end
   // timeout and random stall source
   always @(posedge clk_in)
   begin
      cyc++;
      rnd <= lfsr(rnd);
      if (cyc == 5000)
      begin
         bad_count++;
         results();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      chk("node", 7'h7f, node);
      chk("rate", 10'h07d, kb);
      nd = {rnd[6:1], 1'b1};
      req(2, {8'h11, 1'b0, nd, 8'h0}, 0, 0);
      chk("node", 7'h7f, node);
      req(2, 24'h040100, 0, 0);
      req(2, {8'h11, 1'b0, nd, 8'h0}, 1, 0);
      chk("node", nd, node);
      apb(12'h004, 1, 32'hffffffff);
      apb(12'h004, 0, 32'h00000000);
      chk("stat", nd, q[6:0]);
      // requests disabled by software are dropped without answer
      apb(12'h000, 1, 32'h00000000);
      req(2, {8'h11, 1'b0, ~nd, 8'h0}, 0, 0);
      chk("node", nd, node);
      apb(12'h000, 0, 32'h00000000);
      chk("ctrl", 0, q[0]);
      apb(12'h000, 1, 32'h00000001);
      apb(12'h00c, 0, 32'h00000000);
      chk("slverr", 1, e);
      for (int i = 0; i < 10; i++)
      begin
         req(3, {16'h1300, 8'(i)}, 1, i == 5 || i > 8);
         if (i == 5 || i > 8) continue;
         m.send(3, 24'h150100);
         for (n = 0; sw !== 1'b1 && n < 40; n++) @(posedge clk_in);
         chk("first", 1, n > 9 && n < 16);
         chk("rate", KBPS[i], kb);
         chk("idx", i, idx);
         for (n = 0; hold === 1'b1 && n < 40; n++) @(posedge clk_in);
         chk("second", 1, n > 9 && n < 16);
      end
      req(1, 24'h170000, 1, 0);
      chk("nvm", {nd, 4'h8}, {nvn, nvi});
      m.send(2, 24'h040000);
      @(posedge clk_in);
      chk("preop", 1, prer);
      // reset in mid-run must bring back the factory settings
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      chk("node", 7'h7f, node);
      chk("rate", 10'h07d, kb);
      results();
   end
endmodule // testbench
`default_nettype wire
